// ===== rftac_bank.sv
// How it works
// RULE1 - Clear-on-read field returns its value, then hardware clears it.
// RULE2 - Master writes read-only fields only with their reset value.
// RULE3 - Plain read/write field stores the written value and reads it back.
// RULE4 - Any write to a clear-on-write register clears all its bits.
// RULE5 - Write-one-to-clear: ones clear their bits, zeros leave bits alone.
// RULE6 - Writing back a read status value clears only those reported bits.
// RULE7 - Write-one-to-set: ones set bits, zeros keep them.
// RULE8 - Write-only clear register clears status bits where ones are written.
// RULE9 - Write-only register: writes act, reads complete with no meaning.
// RULE10 - Master preserves reserved bits; device holds them at zero.
// RULE11 - Every field takes its reset value after any reset.
// RULE12 - Each register decodes at a fixed offset from the base.
// RULE13 - Lanes of one register apply their own behaviour in one access.
`timescale 1ns/1ps
`default_nettype none
module rftac_bank
    import rftac_pkg::*;
(
    input  wire logic                    i_clk_sys,
    input  wire logic                    i_rst_n,
    input  wire logic                    i_ce,
    input  wire logic                    i_acc_valid,
    input  wire logic                    i_acc_write,
    input  wire logic [ADDR_W-1:0]       i_acc_addr,
    input  wire logic [31:0]             i_acc_wdata,
    input  wire logic [REG_COUNT*32-1:0] i_hw_event,
    output logic                         o_acc_ack,
    output logic                         o_acc_err,
    output logic      [31:0]             o_acc_rdata,
    output logic      [31:0]             o_rw_value,
    output logic      [31:0]             o_wo_value,
    output logic      [31:0]             o_one_set_value
);

    logic [REG_COUNT-1:0][31:0] reg_val;
    logic [REG_COUNT-1:0]       rd_hit;
    logic [REG_COUNT-1:0]       wr_hit;
    logic                       hit;
    logic [3:0]                 idx;
    logic [31:0]                rd_word;

    // Offset decode, word aligned, relative to the base
    always_comb
    begin
        hit = 1'b1;
        idx = 4'h0;
        if (i_acc_addr == OFF_RW) idx = 4'(IDX_RW); // see RULE12
        else if (i_acc_addr == OFF_RO) idx = 4'(IDX_RO);
        else if (i_acc_addr == OFF_RC) idx = 4'(IDX_RC);
        else if (i_acc_addr == OFF_WANYC) idx = 4'(IDX_WANYC);
        else if (i_acc_addr == OFF_R1C) idx = 4'(IDX_R1C);
        else if (i_acc_addr == OFF_R1S) idx = 4'(IDX_R1S);
        else if (i_acc_addr == OFF_W1C) idx = 4'(IDX_W1C);
        else if (i_acc_addr == OFF_WO) idx = 4'(IDX_WO);
        else if (i_acc_addr == OFF_MIX) idx = 4'(IDX_MIX);
        else hit = 1'b0;
    end

    // Per-register strobes, gated by the clock enable
    always_comb
    begin
        rd_hit = '0;
        wr_hit = '0;
        if (i_acc_valid && i_ce && hit)
        begin
            if (i_acc_write)
                wr_hit[idx] = 1'b1;
            else
                rd_hit[idx] = 1'b1;
        end
    end

    // Lanes of every register; each lane keeps its own behaviour
    for (genvar r = 0; r < REG_COUNT; r++)
    begin : g_reg
        for (genvar l = 0; l < LANES; l++)
        begin : g_lane
            rftac_field #(
                .ACC (acc_of(r, l)),
                .W   (LANE_W),
                .RST (LANE_W'(rst_of(r) >> (l*LANE_W)))
            ) u_field (
                .i_clk_sys (i_clk_sys),
                .i_rst_n   (i_rst_n),
                .i_ce      (i_ce),
                .i_rd      (rd_hit[r]),
                .i_wr      (wr_hit[r]),
                .i_wdata   (i_acc_wdata[l*LANE_W +: LANE_W]),
                .i_hw      (i_hw_event[r*32 + l*LANE_W +: LANE_W]),
                .i_ext_clr ((r == IDX_R1C && wr_hit[IDX_W1C])
                            ? i_acc_wdata[l*LANE_W +: LANE_W]
                            : {LANE_W{1'b0}}), // see RULE8
                .o_value   (reg_val[r][l*LANE_W +: LANE_W])
            ); // see RULE13
        end
    end

    // Read word: write-only lanes read zero rather than stale content
    always_comb
    begin
        rd_word = 32'h0000_0000;
        for (int l = 0; l < LANES; l++)
        begin
            if (readable(acc_of(int'(idx), l)))
                rd_word[l*LANE_W +: LANE_W] = reg_val[idx][l*LANE_W +: LANE_W];
        end
    end

    // Answer one cycle after the request; value is the pre-clear one
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_acc_ack   <= 1'b0;
            o_acc_err   <= 1'b0;
            o_acc_rdata <= 32'h0000_0000;
        end
        else if (i_ce)
        begin
            o_acc_ack <= i_acc_valid;
            o_acc_err <= i_acc_valid && !hit;
            if (i_acc_valid && !i_acc_write)
                o_acc_rdata <= hit ? rd_word : 32'h0000_0000; // see RULE9
        end
    end

    // Copies for the block's own logic, kept in flops for clean outputs
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_rw_value      <= RST_RW;
            o_wo_value      <= RST_WO;
            o_one_set_value <= RST_R1S;
        end
        else if (i_ce)
        begin
            o_rw_value      <= reg_val[IDX_RW];
            o_wo_value      <= reg_val[IDX_WO];
            o_one_set_value <= reg_val[IDX_R1S];
        end
    end

    // Checks on each access behaviour except read-only
    AST_RC_READ_RETURNS: assert property (@(posedge i_clk_sys) // see RULE1
        disable iff (!i_rst_n)
        rd_hit[IDX_RC] |=> o_acc_rdata == $past(reg_val[IDX_RC]))
        else $error("clear-on-read returned wrong value");

    AST_RC_READ_CLEARS: assert property (@(posedge i_clk_sys) // see RULE1
        disable iff (!i_rst_n)
        rd_hit[IDX_RC] |=>
            reg_val[IDX_RC] == $past(i_hw_event[IDX_RC*32 +: 32]))
        else $error("clear-on-read did not clear");

    AST_RW_STORES: assert property (@(posedge i_clk_sys) // see RULE3
        disable iff (!i_rst_n)
        wr_hit[IDX_RW] |=> reg_val[IDX_RW] == $past(i_acc_wdata)
            ##2 (!$past(i_ce) || o_rw_value == $past(reg_val[IDX_RW])))
        else $error("read/write field did not store");

    AST_ANY_WRITE_CLEARS: assert property (@(posedge i_clk_sys) // see RULE4
        disable iff (!i_rst_n)
        wr_hit[IDX_WANYC] |=>
            reg_val[IDX_WANYC] == $past(i_hw_event[IDX_WANYC*32 +: 32]))
        else $error("write did not clear register");

    AST_ONE_CLEARS: assert property (@(posedge i_clk_sys) // see RULE5
        disable iff (!i_rst_n)
        wr_hit[IDX_R1C] |=> reg_val[IDX_R1C] ==
            (($past(reg_val[IDX_R1C]) & ~$past(i_acc_wdata))
             | $past(i_hw_event[IDX_R1C*32 +: 32])))
        else $error("write-one-to-clear wrong result");

    AST_ONE_SETS: assert property (@(posedge i_clk_sys) // see RULE7
        disable iff (!i_rst_n)
        wr_hit[IDX_R1S] |=>
            reg_val[IDX_R1S] == ($past(reg_val[IDX_R1S]) | $past(i_acc_wdata)))
        else $error("write-one-to-set wrong result");

    AST_WO_CLEARS_STATUS: assert property (@(posedge i_clk_sys) // see RULE8
        disable iff (!i_rst_n)
        wr_hit[IDX_W1C] |=> reg_val[IDX_R1C] ==
            (($past(reg_val[IDX_R1C]) & ~$past(i_acc_wdata))
             | $past(i_hw_event[IDX_R1C*32 +: 32])))
        else $error("clear register did not clear status");

    AST_WO_READS_ZERO: assert property (@(posedge i_clk_sys) // see RULE9
        disable iff (!i_rst_n)
        (rd_hit[IDX_WO] || rd_hit[IDX_W1C]) |=>
            o_acc_ack && o_acc_rdata == 32'h0000_0000)
        else $error("write-only read not zero");

    AST_MIXED_LANES: assert property (@(posedge i_clk_sys) // see RULE13
        disable iff (!i_rst_n)
        wr_hit[IDX_MIX] |=> reg_val[IDX_MIX][7:0] == $past(i_acc_wdata[7:0])
            && reg_val[IDX_MIX][31:24] == ($past(reg_val[IDX_MIX][31:24])
                                           | $past(i_acc_wdata[31:24])))
        else $error("mixed register lanes wrong");

endmodule
`default_nettype wire

// ===== rftac_field.sv
`timescale 1ns/1ps
`default_nettype none
module rftac_field
    import rftac_pkg::*;
#(
    parameter rftac_acc_type ACC = RFTAC_ACC_RW,
    parameter int            W   = 8,
    parameter logic [W-1:0]  RST = '0
)
(
    input  wire logic         i_clk_sys,
    input  wire logic         i_rst_n,
    input  wire logic         i_ce,
    input  wire logic         i_rd,
    input  wire logic         i_wr,
    input  wire logic [W-1:0] i_wdata,
    input  wire logic [W-1:0] i_hw,
    input  wire logic [W-1:0] i_ext_clr,
    output logic      [W-1:0] o_value
);

    // One lane of storage; hardware set always wins over any clear
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_value <= RST; // see RULE11
        end
        else if (i_ce)
        begin
            case (ACC)
                RFTAC_ACC_RW, RFTAC_ACC_WO:
                    if (i_wr)
                        o_value <= i_wdata; // see RULE3 see RULE9
                RFTAC_ACC_RO:
                    o_value <= i_hw; // Writes never reach it
                RFTAC_ACC_RC:
                    o_value <= (i_rd ? '0 : o_value) | i_hw; // see RULE1
                RFTAC_ACC_WANYC:
                    o_value <= (i_wr ? '0 : o_value) | i_hw; // see RULE4
                RFTAC_ACC_R1C:
                    o_value <= (o_value & ~(i_wr ? i_wdata : '0)
                               & ~i_ext_clr) | i_hw; // see RULE5 see RULE6
                RFTAC_ACC_R1S:
                    o_value <= o_value | (i_wr ? i_wdata : '0); // see RULE7
                default:
                    o_value <= '0; // Clear-only lane holds no content
            endcase
        end
    end

endmodule
`default_nettype wire

// ===== rftac_master.sv
`timescale 1ns/1ps
`default_nettype none
module rftac_master
    import rftac_pkg::*;
(
    input  wire logic              i_clk_sys,
    input  wire logic              i_acc_ack,
    input  wire logic              i_acc_err,
    input  wire logic [31:0]       i_acc_rdata,
    output logic                   o_acc_valid,
    output logic                   o_acc_write,
    output logic      [ADDR_W-1:0] o_acc_addr,
    output logic      [31:0]       o_acc_wdata
);
    // Quiet bus from time zero
    initial
    begin
        o_acc_valid = 1'h0;
        o_acc_write = 1'h0;
        o_acc_addr  = 8'h00;
        o_acc_wdata = 32'h0000_0000;
    end

    // One access a cycle; entered at a falling edge, valid left high
    task automatic acc(input logic wr, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] rd, output logic ack,
        output logic err);
        o_acc_valid = 1'h1;
        o_acc_write = wr;
        o_acc_addr  = a;
        o_acc_wdata = (a == OFF_RO) ? RST_RO : d;
        @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        ack = i_acc_ack;
        err = i_acc_err;
        rd  = i_acc_rdata;
    endtask

    // Released lines toggle so stale data never looks valid
    task automatic idle();
        o_acc_valid = 1'h0;
        o_acc_addr  = ~o_acc_addr;
        o_acc_wdata = ~o_acc_wdata;
        @(posedge i_clk_sys);
        @(negedge i_clk_sys);
    endtask

    // Masked update keeps every bit outside the mask as read
    task automatic rmw(input logic [7:0] a, input logic [31:0] mask,
        input logic [31:0] val);
        logic [31:0] cur;
        logic        ack;
        logic        err;
        acc(1'h0, a, 32'h0000_0000, cur, ack, err);
        acc(1'h1, a, (cur & ~mask) | (val & mask), cur, ack, err);
    endtask
endmodule
`default_nettype wire

// ===== rftac_pkg.sv
package rftac_pkg;

    // Access behaviour that one byte lane of a register follows
    typedef enum logic [2:0]
    {
        RFTAC_ACC_RW,
        RFTAC_ACC_RO,
        RFTAC_ACC_RC,
        RFTAC_ACC_WANYC,
        RFTAC_ACC_R1C,
        RFTAC_ACC_R1S,
        RFTAC_ACC_W1C,
        RFTAC_ACC_WO
    } rftac_acc_type;

    localparam int          REG_COUNT  = 9;
    localparam int          LANE_W     = 8;
    localparam int          LANES      = 4;
    localparam int          ADDR_W     = 8;

    // Register index; the byte offset is four times the index
    localparam int          IDX_RW     = 0;
    localparam int          IDX_RO     = 1;
    localparam int          IDX_RC     = 2;
    localparam int          IDX_WANYC  = 3;
    localparam int          IDX_R1C    = 4;
    localparam int          IDX_R1S    = 5;
    localparam int          IDX_W1C    = 6;
    localparam int          IDX_WO     = 7;
    localparam int          IDX_MIX    = 8;

    // Byte offsets from the module base address
    localparam logic [7:0]  OFF_RW     = 8'h00;
    localparam logic [7:0]  OFF_RO     = 8'h04;
    localparam logic [7:0]  OFF_RC     = 8'h08;
    localparam logic [7:0]  OFF_WANYC  = 8'h0C;
    localparam logic [7:0]  OFF_R1C    = 8'h10;
    localparam logic [7:0]  OFF_R1S    = 8'h14;
    localparam logic [7:0]  OFF_W1C    = 8'h18;
    localparam logic [7:0]  OFF_WO     = 8'h1C;
    localparam logic [7:0]  OFF_MIX    = 8'h20;

    // Reset values
    localparam logic [31:0] RST_RW     = 32'h0000_0000;
    localparam logic [31:0] RST_RO     = 32'h0000_0000;
    localparam logic [31:0] RST_STATUS = 32'h0000_0000;
    localparam logic [31:0] RST_R1S    = 32'h0000_0000;
    localparam logic [31:0] RST_WO     = 32'h0000_0000;
    localparam logic [31:0] RST_MIX    = 32'h0000_0000;

    // Access type of lane l of register r
    function automatic rftac_acc_type acc_of(input int r, input int l);
        rftac_acc_type a;
        a = RFTAC_ACC_RW;
        if (r == IDX_RO) a = RFTAC_ACC_RO;
        else if (r == IDX_RC) a = RFTAC_ACC_RC;
        else if (r == IDX_WANYC) a = RFTAC_ACC_WANYC;
        else if (r == IDX_R1C) a = RFTAC_ACC_R1C;
        else if (r == IDX_R1S) a = RFTAC_ACC_R1S;
        else if (r == IDX_W1C) a = RFTAC_ACC_W1C;
        else if (r == IDX_WO) a = RFTAC_ACC_WO;
        else if (r == IDX_MIX && l == 1) a = RFTAC_ACC_RC;
        else if (r == IDX_MIX && l == 2) a = RFTAC_ACC_R1C;
        else if (r == IDX_MIX && l == 3) a = RFTAC_ACC_R1S;
        return a;
    endfunction

    // Reset word of register r
    function automatic logic [31:0] rst_of(input int r);
        logic [31:0] v;
        v = RST_STATUS;
        if (r == IDX_RW) v = RST_RW;
        else if (r == IDX_RO) v = RST_RO;
        else if (r == IDX_R1S) v = RST_R1S;
        else if (r == IDX_WO) v = RST_WO;
        else if (r == IDX_MIX) v = RST_MIX;
        return v;
    endfunction

    // Lanes whose read returns their content
    function automatic logic readable(input rftac_acc_type a);
        return (a != RFTAC_ACC_W1C) && (a != RFTAC_ACC_WO);
    endfunction

endpackage

// ===== testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import rftac_pkg::*;
    logic                    clk;
    logic                    rst_n;
    logic                    ce;
    logic [REG_COUNT*32-1:0] hw;
    logic                    valid;
    logic                    wr;
    logic [ADDR_W-1:0]       addr;
    logic [31:0]             wdata;
    logic                    ack;
    logic                    err;
    logic [31:0]             rdata;
    logic [31:0]             rw_v;
    logic [31:0]             wo_v;
    logic [31:0]             os_v;
    logic [31:0]             m [REG_COUNT];
    logic [31:0]             v;
    int                      evr [4] = '{IDX_RC, IDX_WANYC, IDX_R1C, IDX_MIX};
    int                      failures;
    int                      tests_run;

    rftac_bank dut_u (.i_clk_sys(clk), .i_rst_n(rst_n), .i_ce(ce),
        .i_acc_valid(valid), .i_acc_write(wr), .i_acc_addr(addr),
        .i_acc_wdata(wdata), .i_hw_event(hw), .o_acc_ack(ack),
        .o_acc_err(err), .o_acc_rdata(rdata), .o_rw_value(rw_v),
        .o_wo_value(wo_v), .o_one_set_value(os_v));
    rftac_master master_u (.i_clk_sys(clk), .i_acc_ack(ack),
        .i_acc_err(err), .i_acc_rdata(rdata), .o_acc_valid(valid),
        .o_acc_write(wr), .o_acc_addr(addr), .o_acc_wdata(wdata));

    task automatic tally_and_finish();
        if (failures == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_flag(input logic got, input logic exp);
        cmp_word({31'h0, got}, {31'h0, exp});
    endtask

    // Reference behaviour of one access; reads see the value before clear
    task automatic model(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic e);
        int i;
        i = int'(a) / 4;
        e = (a > OFF_MIX);
        r = 32'h0000_0000;
        if (!e && !w)
        begin
            if (i != IDX_W1C && i != IDX_WO) r = m[i];
            if (i == IDX_RC) m[i] = 32'h0000_0000;
            if (i == IDX_MIX) m[i][15:8] = 8'h00;
        end
        else if (!e)
        case (i)
            IDX_RW: m[i] = d;
            IDX_WANYC: m[i] = 32'h0000_0000;
            IDX_R1C: m[i] = m[i] & ~d;
            IDX_R1S: m[i] = m[i] | d;
            IDX_W1C: m[IDX_R1C] = m[IDX_R1C] & ~d;
            IDX_WO: m[i] = d;
            IDX_MIX: m[i] = {m[i][31:24] | d[31:24],
                m[i][23:16] & ~d[23:16], m[i][15:8], d[7:0]};
            default: ;
        endcase
    endtask

    task automatic run(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        logic [31:0] er;
        logic [31:0] gr;
        logic        ee;
        logic        ga;
        logic        ge;
        model(w, a, d, er, ee);
        master_u.acc(w, a, d, gr, ga, ge);
        cmp_flag(ga, 1'h1);
        cmp_flag(ge, ee);
        if (!w) cmp_word(gr, er);
    endtask

    // One-cycle hardware event; in the mixed register only the clear-on-read and write-one-to-clear lanes take it
    task automatic pulse(input int r, input logic [31:0] b);
        hw[r*32 +: 32] = b;
        master_u.idle();
        hw[r*32 +: 32] = 32'h0000_0000;
        m[r] = m[r] | ((r == IDX_MIX) ? (b & 32'h00FF_FF00) : b);
        master_u.idle();
    endtask

    // Copies trail the register by one edge, so look after a quiet cycle
    task automatic idle_chk();
        master_u.idle();
        cmp_flag(ack, 1'h0);
        cmp_word(rw_v, m[IDX_RW]);
        cmp_word(wo_v, m[IDX_WO]);
        cmp_word(os_v, m[IDX_R1S]);
    endtask

    // Enable low: the access is not taken and no field or copy moves
    task automatic frozen();
        logic [31:0] gr;
        logic        ga;
        logic        ge;
        ce = 1'h0;
        master_u.acc(1'h1, OFF_RW, ~m[IDX_RW], gr, ga, ge);
        cmp_flag(ga, 1'h0);
        ce = 1'h1;
        master_u.idle();
        cmp_word(rw_v, m[IDX_RW]);
        run(1'h0, OFF_RW, 32'h0000_0000);
    endtask

    task automatic rd_all();
        for (int j = 0; j <= REG_COUNT + 1; j++)
            run(1'h0, 8'(j * 4), 32'h0000_0000);
    endtask

    initial
    begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    // Whole run is under two hundred cycles; this bound only catches a hang
    initial
    begin
        #100000;
        failures++;
        tally_and_finish();
    end

    initial
    begin
        failures = 0;
        tests_run = 0;
        ce = 1'h1;
        hw = '0;
        rst_n = 1'h0;
        m = '{default: 32'h0000_0000};
        void'($urandom(32'h8B02));
        repeat (5) @(negedge clk);
        rst_n = 1'h1;
        rd_all();
        v = $urandom();
        run(1'h1, OFF_RW, v);
        run(1'h0, OFF_RW, 32'h0000_0000);
        master_u.rmw(OFF_RW, 32'h0000_FFFF, ~v);
        m[IDX_RW] = {v[31:16], ~v[15:0]};
        run(1'h0, OFF_RW, 32'h0000_0000);
        hw[IDX_RO*32 +: 32] = $urandom();
        m[IDX_RO] = hw[IDX_RO*32 +: 32];
        master_u.idle();
        run(1'h1, OFF_RO, 32'hFFFF_FFFF);
        run(1'h0, OFF_RO, 32'h0000_0000);
        pulse(IDX_RC, $urandom());
        run(1'h0, OFF_RC, 32'h0000_0000);
        run(1'h0, OFF_RC, 32'h0000_0000);
        pulse(IDX_WANYC, $urandom());
        run(1'h0, OFF_WANYC, 32'h0000_0000);
        run(1'h1, OFF_WANYC, 32'h0000_0000);
        run(1'h0, OFF_WANYC, 32'h0000_0000);
        pulse(IDX_R1C, $urandom());
        run(1'h1, OFF_R1C, 32'h0000_0000);
        run(1'h0, OFF_R1C, 32'h0000_0000);
        v = m[IDX_R1C];
        pulse(IDX_R1C, $urandom());
        run(1'h1, OFF_R1C, v);
        run(1'h0, OFF_R1C, 32'h0000_0000);
        run(1'h1, OFF_R1S, $urandom());
        run(1'h1, OFF_R1S, 32'h0000_0000);
        run(1'h0, OFF_R1S, 32'h0000_0000);
        pulse(IDX_R1C, $urandom());
        run(1'h1, OFF_W1C, $urandom());
        run(1'h0, OFF_W1C, 32'h0000_0000);
        run(1'h0, OFF_R1C, 32'h0000_0000);
        run(1'h1, OFF_WO, $urandom());
        run(1'h0, OFF_WO, 32'h0000_0000);
        pulse(IDX_MIX, $urandom());
        run(1'h1, OFF_MIX, $urandom());
        run(1'h0, OFF_MIX, 32'h0000_0000);
        run(1'h0, OFF_MIX, 32'h0000_0000);
        idle_chk();
        for (int k = 0; k < 60; k++)
        begin
            if (k % 6 == 0)
                pulse(evr[$urandom_range(3)], $urandom());
            run(1'($urandom()), 8'($urandom_range(10) * 4), $urandom());
        end
        idle_chk();
        frozen();
        idle_chk();
        // Reset in mid-run drops every output and every field
        rst_n = 1'h0;
        @(posedge clk);
        @(negedge clk);
        cmp_word(rdata, 32'h0000_0000);
        cmp_word(rw_v | wo_v | os_v, 32'h0000_0000);
        rst_n = 1'h1;
        m = '{default: 32'h0000_0000};
        m[IDX_RO] = hw[IDX_RO*32 +: 32];
        master_u.idle();
        rd_all();
        tally_and_finish();
    end
endmodule
`default_nettype wire
